// ===== hw/vcr_regs.sv
// Channel 0 control and status and channel 1 capability registers.
`timescale 1ns/1ps
module vcr_regs #(
    parameter int PHASES  = vcr_pkg::VCR_PHASES,
    parameter int PHASE_W = $clog2(vcr_pkg::VCR_PHASES)
) (
    input  wire logic                     clk,
    input  wire logic                     reset_n,
    input  wire logic [vcr_pkg::VCR_AW-1:0] reg_addr,
    input  wire logic [31:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic [31:0]                   reg_rdata,
    input  wire logic                     cap_strap,
    input  wire logic                     autoload_valid,
    input  wire logic [7:0]               autoload_map,
    input  wire logic [6:0]               autoload_slots,
    input  wire logic                     table_entry_wr,
    input  wire logic                     negotiation_busy,
    output logic [7:0]                    class_to_channel_map,
    output logic [2:0]                    arb_select,
    output logic [2:0]                    channel_identifier,
    output logic                          channel_enable,
    output logic                          table_load_start,
    output logic                          table_loading,
    output logic [PHASE_W-1:0]            table_phase
);
    import vcr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Functions.

    // Only the two schemes this channel supports are kept; anything else
    // falls back to the default so the scheduler never sees a bad code.
    function automatic logic [2:0] legal_select(input logic [2:0] req);
        logic [2:0] res;
        res = VCR_SEL_DFLT;
        if (req == VCR_SEL_WRR) begin
            res = VCR_SEL_WRR;
        end
        return res;
    endfunction

    // Picks the on or off reset image of a strap-dependent byte.
    function automatic logic [7:0] by_strap(input logic sel,
                                            input logic [7:0] on_v,
                                            input logic [7:0] off_v);
        return sel ? on_v : off_v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release through two flip-flops.
    // The pin may fall at any time but rises in step here;
    // the second stage hides a metastable release.
    // Every flop below resets from this copy.
    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Decode.
    // Addresses compare in full; no register has an alias.
    logic hit_ctrl0;
    logic hit_stat0;
    logic hit_cap1;
    logic wr_ctrl0;

    assign hit_ctrl0 = (reg_addr == VCR_CTRL0_OFS);
    assign hit_stat0 = (reg_addr == VCR_STAT0_OFS);
    assign hit_cap1  = (reg_addr == VCR_CAP1_OFS);
    assign wr_ctrl0  = reg_wr && hit_ctrl0;

    ////////////////////////////////////////////////////////////////////////////////
    // Strap capture. The extended capability bit is sampled by a clocked
    // process in the first cycle after reset release, never by the reset.
    // A strap that moves later waits for the next reset.
    // Until then channel 1 reads as if the strap were low.
    logic strap_done_q;
    logic strap_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_done_q <= 1'b0;
            strap_q      <= 1'b0;
        end else if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            strap_q      <= cap_strap;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Channel 0 class map. Software writes win over an autoload arriving
    // in the same cycle, since software always speaks last.
    logic [7:0] map_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            map_q <= VCR_MAP_RST;
        end else if (wr_ctrl0) begin
            map_q <= reg_wdata[VCR_MAP_LSB +: VCR_MAP_W];
        end else if (autoload_valid) begin
            map_q <= autoload_map;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Channel 0 arbitration select.
    // Filtering on write keeps the stored code legal.
    logic [2:0] sel_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_q <= VCR_SEL_DFLT;
        end else if (wr_ctrl0) begin
            sel_q <= legal_select(reg_wdata[VCR_SEL_LSB +: VCR_SEL_W]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Channel 0 identifier: held in a flop for a clean output, never written.
    // Writes to these bits are dropped.
    logic [2:0] id_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            id_q <= VCR_ID0;
        end else begin
            id_q <= VCR_ID0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Channel 0 enable.
    // It leaves reset set, so the channel runs unconfigured.
    logic en_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_q <= VCR_EN_RST;
        end else if (wr_ctrl0) begin
            en_q <= reg_wdata[VCR_EN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Load command: a one-cycle pulse, never stored as a readable bit.
    // Writing zero to the bit does nothing.
    logic load_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            load_q <= 1'b0;
        end else begin
            load_q <= wr_ctrl0 && reg_wdata[VCR_LOAD_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Table loader. A load request while a load runs is dropped by the
    // loader; the status bit then clears at the end of the running load.
    // A small PHASES suits test only.
    logic               ld_busy;
    logic               ld_done;
    logic [PHASE_W-1:0] ld_phase;

    vcr_table_loader #(
        .PHASES  (PHASES),
        .PHASE_W (PHASE_W)
    ) u_loader (
        .clk   (clk),
        .rst_n (rst_n),
        .start (load_q),
        .busy  (ld_busy),
        .done  (ld_done),
        .phase (ld_phase)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Table status. A table write in the same cycle as load completion
    // keeps the bit set: that entry has not reached the hardware yet.
    logic tstat_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tstat_q <= 1'b0;
        end else if (table_entry_wr) begin
            tstat_q <= 1'b1;
        end else if (ld_done) begin
            tstat_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Negotiation pending follows the link layer's level.
    // The lag is harmless, since software polls this bit.
    logic neg_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            neg_q <= 1'b0;
        end else begin
            neg_q <= negotiation_busy;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Channel 1 time slots: strap image once, then autoload may replace it.
    // An autoloaded value stands until the next autoload or reset.
    logic [6:0] slots_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slots_q <= VCR_SLOT_OFF;
        end else if (!strap_done_q) begin
            slots_q <= cap_strap ? VCR_SLOT_ON : VCR_SLOT_OFF;
        end else if (autoload_valid) begin
            slots_q <= autoload_slots;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register images. Reserved bits stay zero and nothing writes them.
    // Images are combinational; the read port registers them.
    logic [31:0] ctrl0_img;
    logic [31:0] stat0_img;
    logic [31:0] cap1_img;

    // Control image: the load bit reads back as zero.
    always_comb begin
        ctrl0_img                              = VCR_ZERO;
        ctrl0_img[VCR_MAP_LSB +: VCR_MAP_W]    = map_q;
        ctrl0_img[VCR_LOAD_BIT]                = 1'b0;
        ctrl0_img[VCR_SEL_LSB +: VCR_SEL_W]    = sel_q;
        ctrl0_img[VCR_ID_LSB +: VCR_ID_W]      = id_q;
        ctrl0_img[VCR_EN_BIT]                  = en_q;
    end

    // Status image: the rest reads zero.
    always_comb begin
        stat0_img                = VCR_ZERO;
        stat0_img[VCR_TSTAT_BIT] = tstat_q;
        stat0_img[VCR_NEG_BIT]   = neg_q;
    end

    // Capability byte carries round robin, weighted and time-based bits.
    // The strap alone picks the byte and the table offset.
    always_comb begin
        cap1_img                                 = VCR_ZERO;
        cap1_img[VCR_PCAP_LSB +: VCR_PCAP_W]     = by_strap(strap_q, VCR_PCAP_ON, VCR_PCAP_OFF);
        cap1_img[VCR_AS_BIT]                     = VCR_AS_VAL;
        cap1_img[VCR_SLOT_LSB +: VCR_SLOT_W]     = slots_q;
        cap1_img[VCR_TOFS_LSB +: VCR_TOFS_W]     = by_strap(strap_q, VCR_TOFS_ON, VCR_TOFS_OFF);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read port. Data stand only in the cycle after the strobe; an unmapped
    // address answers zero rather than stalling the master.
    // Zero between reads keeps stale data off the bus.
    logic [31:0] rdata_q;
    logic [31:0] rd_val;

    always_comb begin
        rd_val = VCR_ZERO;
        if (hit_ctrl0) begin
            rd_val = ctrl0_img;
        end else if (hit_stat0) begin
            rd_val = stat0_img;
        end else if (hit_cap1) begin
            rd_val = cap1_img;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= VCR_ZERO;
        end else if (reg_rd) begin
            rdata_q <= rd_val;
        end else begin
            rdata_q <= VCR_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs, each straight from a flop.
    // The loader's busy flag is a flop, so no decode sits on a pin.
    assign reg_rdata            = rdata_q;
    assign class_to_channel_map = map_q;
    assign arb_select           = sel_q;
    assign channel_identifier   = id_q;
    assign channel_enable       = en_q;
    assign table_load_start     = load_q;
    assign table_loading        = ld_busy;
    assign table_phase          = ld_phase;

endmodule

// ===== hw/vcr_pkg.sv
// Constants, field layout and state codes for the channel resource registers.
// Operation
// - Channel 0 map bit n maps class n; resets FFh, autoload may override.
// - Writing one to bit 16 applies the arbitration table; reads zero.
// - Channel 0 select accepts 000b and 011b; others become 000b; resets 000b.
// - Channel 0 identifier is read-only and reads 000b.
// - Bit 31 enables channel 0 when one; resets to one.
// - Table status bit 16 sets when software writes any table entry.
// - Table status clears when hardware finishes loading the stored table.
// - Negotiation pending bit 17 is one while negotiating; resets zero.
// - Channel 1 arbitration capability resets 19h or 00h by strap.
// - Round robin and weighted round robin 128 phases; time-based only channel 1.
// - Channel 1 max time slots resets 7Fh or 00h; autoload may override.
// - Channel 1 table offset in 16-byte units resets 08h or 00h.
// - Channel 1 advanced switching only bit reads zero.
package vcr_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register offsets.
    localparam int          VCR_AW        = 12;
    localparam logic [11:0] VCR_CTRL0_OFS = 12'h154;
    localparam logic [11:0] VCR_STAT0_OFS = 12'h158;
    localparam logic [11:0] VCR_CAP1_OFS  = 12'h15c;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int VCR_MAP_LSB   = 0;
    localparam int VCR_MAP_W     = 8;
    localparam int VCR_LOAD_BIT  = 16;
    localparam int VCR_SEL_LSB   = 17;
    localparam int VCR_SEL_W     = 3;
    localparam int VCR_ID_LSB    = 24;
    localparam int VCR_ID_W      = 3;
    localparam int VCR_EN_BIT    = 31;
    localparam int VCR_TSTAT_BIT = 16;
    localparam int VCR_NEG_BIT   = 17;
    localparam int VCR_PCAP_LSB  = 0;
    localparam int VCR_PCAP_W    = 8;
    localparam int VCR_AS_BIT    = 14;
    localparam int VCR_SLOT_LSB  = 16;
    localparam int VCR_SLOT_W    = 7;
    localparam int VCR_TOFS_LSB  = 24;
    localparam int VCR_TOFS_W    = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset and fixed values.
    localparam logic [7:0] VCR_MAP_RST   = 8'hff;
    localparam logic [2:0] VCR_SEL_DFLT  = 3'h0;
    localparam logic [2:0] VCR_SEL_WRR   = 3'h3;
    localparam logic [2:0] VCR_ID0       = 3'h0;
    localparam logic       VCR_EN_RST    = 1'b1;
    localparam logic [7:0] VCR_PCAP_ON   = 8'h19;
    localparam logic [7:0] VCR_PCAP_OFF  = 8'h00;
    localparam logic [6:0] VCR_SLOT_ON   = 7'h7f;
    localparam logic [6:0] VCR_SLOT_OFF  = 7'h00;
    localparam logic [7:0] VCR_TOFS_ON   = 8'h08;
    localparam logic [7:0] VCR_TOFS_OFF  = 8'h00;
    localparam logic       VCR_AS_VAL    = 1'b0;
    localparam logic [31:0] VCR_ZERO     = 32'h0000_0000;

    // Capability bits: fixed round robin, weighted 128 phase, time-based 128 phase.
    localparam int VCR_CAP_RR_BIT    = 0;
    localparam int VCR_CAP_WRR_BIT   = 3;
    localparam int VCR_CAP_TWRR_BIT  = 4;

    // Number of arbitration phases walked by one table load.
    localparam int VCR_PHASES = 128;

    ////////////////////////////////////////////////////////////////////////////////
    // Table loader states.
    typedef enum logic [1:0] {
        VCR_LD_IDLE = 2'b00,
        VCR_LD_RUN  = 2'b01,
        VCR_LD_DONE = 2'b10
    } vcr_ld_state_t;

endpackage

// ===== hw/vcr_table_loader.sv
// Sequencer that walks the stored arbitration table into the scheduler.
`timescale 1ns/1ps
module vcr_table_loader #(
    parameter int PHASES  = vcr_pkg::VCR_PHASES,
    parameter int PHASE_W = $clog2(vcr_pkg::VCR_PHASES)
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               start,
    output logic                    busy,
    output logic                    done,
    output logic [PHASE_W-1:0]      phase
);
    import vcr_pkg::*;

    localparam logic [PHASE_W-1:0] LAST = PHASE_W'(PHASES - 1);

    vcr_ld_state_t      state_q;
    vcr_ld_state_t      state_d;
    logic [PHASE_W-1:0] phase_q;
    logic               done_q;
    logic               busy_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Next state: a start while running is ignored so a load is never torn.
    always_comb begin
        state_d = state_q;
        case (state_q)
            VCR_LD_IDLE: begin
                if (start) begin
                    state_d = VCR_LD_RUN;
                end
            end
            VCR_LD_RUN: begin
                if (phase_q == LAST) begin
                    state_d = VCR_LD_DONE;
                end
            end
            VCR_LD_DONE: state_d = VCR_LD_IDLE;
            default:     state_d = VCR_LD_IDLE;
        endcase
    end

    // State register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= VCR_LD_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Phase counter steps once per cycle while running.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= '0;
        end else if (state_q == VCR_LD_RUN) begin
            phase_q <= (phase_q == LAST) ? '0 : phase_q + 1'b1;
        end else begin
            phase_q <= '0;
        end
    end

    // Completion pulse, one cycle, in the cycle after the last phase is written.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done_q <= 1'b0;
        end else begin
            done_q <= (state_q == VCR_LD_RUN) && (phase_q == LAST);
        end
    end

    // Busy is registered so that it can drive a pin directly.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= (state_d == VCR_LD_RUN);
        end
    end

    assign busy  = busy_q;
    assign done  = done_q;
    assign phase = phase_q;

endmodule

// ===== test/vcr_regs_monitor.sv
// Port checker for the channel resource register bank.
`timescale 1ns/1ps
module vcr_regs_monitor #(
    parameter int PHASES  = vcr_pkg::VCR_PHASES,
    parameter int PHASE_W = $clog2(vcr_pkg::VCR_PHASES)
) (
    input wire logic                         clk,
    input wire logic                         reset_n,
    input wire logic [vcr_pkg::VCR_AW-1:0]   reg_addr,
    input wire logic [31:0]                  reg_wdata,
    input wire logic                         reg_wr,
    input wire logic                         reg_rd,
    input wire logic [31:0]                  reg_rdata,
    input wire logic                         negotiation_busy,
    input wire logic [7:0]                   class_to_channel_map,
    input wire logic [2:0]                   arb_select,
    input wire logic [2:0]                   channel_identifier,
    input wire logic                         channel_enable,
    input wire logic                         table_load_start,
    input wire logic                         table_loading,
    input wire logic [PHASE_W-1:0]           table_phase
);
    import vcr_pkg::*;

    // All properties share one clock and the pin reset.
    default clocking dcb @(posedge clk); endclocking
    default disable iff (!reset_n);

    logic [31:0] wdata_q;
    logic        wr_ctrl;
    logic        rd_ctrl;
    logic        rd_stat;
    logic        rd_cap;
    logic        rd_none;

    ////////////////////////////////////////
    // Decoded strobes; the write data copy lets a property look at fields of the last cycle.
    assign wr_ctrl = reg_wr && reg_addr == VCR_CTRL0_OFS;
    assign rd_ctrl = reg_rd && reg_addr == VCR_CTRL0_OFS;
    assign rd_stat = reg_rd && reg_addr == VCR_STAT0_OFS;
    assign rd_cap  = reg_rd && reg_addr == VCR_CAP1_OFS;
    assign rd_none = reg_rd && !rd_ctrl && !rd_stat && !rd_cap;

    // Holds the write data of the previous cycle.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wdata_q <= VCR_ZERO;
        end else begin
            wdata_q <= reg_wdata;
        end
    end

    ////////////////////////////////////////

    id_fixed_a:
        assert property (channel_identifier == VCR_ID0) else $error("channel identifier not zero");
    sel_legal_a:
        assert property (arb_select == VCR_SEL_DFLT || arb_select == VCR_SEL_WRR) else $error("illegal select");
    sel_write_a:
        assert property (wr_ctrl |=> arb_select == ((wdata_q[19:17] == VCR_SEL_WRR) ? VCR_SEL_WRR : VCR_SEL_DFLT))
        else $error("select write wrong");
    map_enable_write_a:
        assert property (wr_ctrl |=> class_to_channel_map == wdata_q[7:0] && channel_enable == wdata_q[31])
        else $error("map or enable write wrong");
    load_pulse_a:
        assert property (wr_ctrl && reg_wdata[16] |=> table_load_start) else $error("load pulse missing");
    load_begin_a:
        assert property (table_load_start && !table_loading && !$past(table_loading) |=> table_loading
            && table_phase == '0) else $error("load did not begin");
    load_step_a:
        assert property (table_loading && table_phase != PHASE_W'(PHASES - 1) |=> table_loading
            && table_phase == $past(table_phase) + 1'b1) else $error("load phase step wrong");
    load_end_a:
        assert property (table_loading && table_phase == PHASE_W'(PHASES - 1) |=> !table_loading)
        else $error("load did not end");
    ctrl_read_a:
        assert property (rd_ctrl |=> reg_rdata == {$past(channel_enable), 4'h0, $past(channel_identifier), 4'h0,
            $past(arb_select), 1'b0, 8'h00, $past(class_to_channel_map)}) else $error("control image wrong");
    stat_read_a:
        assert property (rd_stat |=> reg_rdata[17] == $past(negotiation_busy, 2) && reg_rdata[31:18] == 14'h0000
            && reg_rdata[15:0] == 16'h0000) else $error("status image wrong");
    cap_read_a:
        assert property (rd_cap |=> reg_rdata[15:8] == 8'h00 && reg_rdata[23] == 1'b0)
        else $error("capability reserved bits set");
    unmapped_read_a:
        assert property (rd_none |=> reg_rdata == VCR_ZERO) else $error("unmapped read not zero");
endmodule

// ===== test/vcr_tb.sv
// Self-checking bench for the channel resource register bank.
`timescale 1ns/1ps
module tb;
    import vcr_pkg::*;

    localparam int PHASES  = 4;
    localparam int PHASE_W = 2;

    logic clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, cap_strap = 1'b1;
    logic autoload_valid = 1'b0, table_entry_wr = 1'b0, negotiation_busy = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata;
    logic [7:0] autoload_map = 8'h00, class_to_channel_map;
    logic [6:0] autoload_slots = 7'h00;
    logic [2:0] arb_select, channel_identifier;
    logic channel_enable, table_load_start, table_loading;
    logic [PHASE_W-1:0] table_phase;
    int mismatches = 0;
    int samples_checked = 0;

    // A short table keeps each load at a few cycles.
    vcr_regs #(.PHASES(PHASES), .PHASE_W(PHASE_W)) dut_u (
        .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cap_strap(cap_strap), .autoload_valid(autoload_valid),
        .autoload_map(autoload_map), .autoload_slots(autoload_slots), .table_entry_wr(table_entry_wr),
        .negotiation_busy(negotiation_busy), .class_to_channel_map(class_to_channel_map),
        .arb_select(arb_select), .channel_identifier(channel_identifier), .channel_enable(channel_enable),
        .table_load_start(table_load_start), .table_loading(table_loading), .table_phase(table_phase));

    // 20 MHz clock.
    initial begin
        forever #25 clk = ~clk;
    end

    ////////////////////////////////////////
    // Shared bus and compare tasks.
    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        samples_checked++;
        if (seen !== expd) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, expd);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data is taken mid-cycle, where it has settled and still stands.
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask

    // The strap only counts if it is steady across the release.
    task automatic do_reset(input logic strap);
        @(posedge clk);
        reset_n <= 1'b0;
        cap_strap <= strap;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask

    ////////////////////////////////////////
    // Scenarios.
    task automatic t_reset_values(input logic strap);
        logic [31:0] d;
        rd(VCR_CTRL0_OFS, d);
        check(d, 32'h8000_00ff);
        rd(VCR_STAT0_OFS, d);
        check(d, 32'h0000_0000);
        rd(VCR_CAP1_OFS, d);
        check(d, strap ? 32'h087f_0019 : 32'h0000_0000);
        $display("reset values done, strap %0d", strap);
    endtask

    // Every select code, with reserved bits and identifier bits 26:25 written as ones.
    task automatic t_select;
        logic [31:0] d, wd, ex;
        logic [2:0] v;
        for (int i = 0; i < 8; i++) begin
            v = i[2:0];
            wd = 32'h7ef0_ff00 | (32'(v) << 17) | 32'(8'h35 + 8'(v)) | (v[0] ? 32'h8000_0000 : 32'h0000_0000);
            ex = (wd & 32'h8000_00ff) | ((v == 3'h3) ? 32'h0006_0000 : 32'h0000_0000);
            wr(VCR_CTRL0_OFS, wd);
            rd(VCR_CTRL0_OFS, d);
            check(d, ex);
            check({29'h0, arb_select}, 32'(ex[19:17]));
        end
        $display("select codes done");
    endtask

    task automatic t_readonly;
        logic [31:0] d;
        wr(VCR_CTRL0_OFS, 32'h8000_00a5);
        wr(VCR_STAT0_OFS, 32'hffff_ffff);
        wr(VCR_CAP1_OFS, 32'hffff_ffff);
        wr(12'h150, 32'hffff_ffff);
        rd(VCR_STAT0_OFS, d);
        check(d, 32'h0000_0000);
        rd(VCR_CAP1_OFS, d);
        check(d, 32'h087f_0019);
        rd(12'h150, d);
        check(d, 32'h0000_0000);
        rd(VCR_CTRL0_OFS, d);
        check(d, 32'h8000_00a5);
        $display("read-only places done");
    endtask

    // Table entry write sets the status; a completed load clears it.
    task automatic t_load;
        logic [31:0] d;
        int cnt;
        @(posedge clk);
        table_entry_wr <= 1'b1;
        @(posedge clk);
        table_entry_wr <= 1'b0;
        rd(VCR_STAT0_OFS, d);
        check(d, 32'h0001_0000);
        wr(VCR_CTRL0_OFS, 32'h8001_00a5);
        cnt = 0;
        for (int n = 0; n < 20; n++) begin
            @(negedge clk);
            if (table_loading === 1'b1) begin
                cnt++;
            end
        end
        check(32'(cnt), 32'(PHASES));
        rd(VCR_STAT0_OFS, d);
        check(d, 32'h0000_0000);
        rd(VCR_CTRL0_OFS, d);
        check(d, 32'h8000_00a5);
        $display("table load done");
    endtask

    task automatic t_negotiate;
        logic [31:0] d;
        @(posedge clk);
        negotiation_busy <= 1'b1;
        repeat (2) @(posedge clk);
        rd(VCR_STAT0_OFS, d);
        check(d, 32'h0002_0000);
        @(posedge clk);
        negotiation_busy <= 1'b0;
        repeat (2) @(posedge clk);
        rd(VCR_STAT0_OFS, d);
        check(d, 32'h0000_0000);
        $display("negotiation done");
    endtask

    task automatic t_autoload;
        logic [31:0] d;
        @(posedge clk);
        autoload_valid <= 1'b1;
        autoload_map <= 8'h5a;
        autoload_slots <= 7'h33;
        @(posedge clk);
        autoload_valid <= 1'b0;
        rd(VCR_CTRL0_OFS, d);
        check(d, 32'h8000_005a);
        rd(VCR_CAP1_OFS, d);
        check(d, 32'h0833_0019);
        $display("autoload done");
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Main sequence; the second reset covers the strap-low values.
    initial begin
        do_reset(1'b1);
        t_reset_values(1'b1);
        t_select();
        t_readonly();
        t_load();
        t_negotiate();
        t_autoload();
        do_reset(1'b0);
        t_reset_values(1'b0);
        wrap_up();
    end
endmodule

bind vcr_regs vcr_regs_monitor #(.PHASES(PHASES), .PHASE_W(PHASE_W)) mon_u (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .negotiation_busy(negotiation_busy), .class_to_channel_map(class_to_channel_map),
    .arb_select(arb_select), .channel_identifier(channel_identifier), .channel_enable(channel_enable),
    .table_load_start(table_load_start), .table_loading(table_loading), .table_phase(table_phase));
